// *** verilog/ixp_defines.vh ***
// constants of the interrupt expander: offsets, fields, reset values, codes
`ifndef IXP_DEFINES_VH
`define IXP_DEFINES_VH

// register bus
`define IXP_ADDR_W         12
`define IXP_OFS_CTRL       12'h000
`define IXP_OFS_ACK        12'h004
`define IXP_OFS_EN_BASE    12'h040
`define IXP_OFS_FLG_BASE   12'h080
`define IXP_OFS_RAM_BASE   12'h400
`define IXP_RESP_OKAY      2'h0
`define IXP_RESP_SLVERR    2'h2

// expander_control fields and register reset values
`define IXP_CTRL_FETCH_BIT 0
`define IXP_CTRL_RST       1'h0
`define IXP_ACK_RST        12'h000
`define IXP_EN_RST         96'h0
`define IXP_FLG_RST        96'h0

// address decode regions
`define IXP_RG_CTRL        3'h0
`define IXP_RG_ACK         3'h1
`define IXP_RG_EN          3'h2
`define IXP_RG_FLG         3'h3
`define IXP_RG_RAM         3'h4
`define IXP_RG_BAD         3'h5

// vector table layout
`define IXP_GROUPS         12
`define IXP_SRCS           8
`define IXP_GRP_ENTRY_BASE 7'h20
`define IXP_RESET_ENTRY    7'h00
`define IXP_ZERO_VECTOR    32'h0000_0000

`endif

// *** verilog/ixp_vec_ram.v ***
// vector memory: 256 x 16 words, byte-lane writes, entry and word read ports
`timescale 1ns/100ps
`default_nettype none
module ixp_vec_ram #(
  parameter AW = 8,
  parameter DW = 16,
  parameter EW = 7
) (
  input  wire            clk,
  input  wire [1:0]      we,
  input  wire [AW-1:0]   waddr,
  input  wire [DW-1:0]   wdata,
  input  wire [EW-1:0]   entry,
  output reg  [2*DW-1:0] entry_q_r,
  input  wire [AW-1:0]   raddr,
  output wire [DW-1:0]   rdata
);
  // no reset: contents undefined after reset
  reg [DW-1:0] mem_r [0:(1<<AW)-1]; // R9

  always @(posedge clk) begin
    if (we[0]) begin
      mem_r[waddr][DW/2-1:0] <= wdata[DW/2-1:0];
    end
    if (we[1]) begin
      mem_r[waddr][DW-1:DW/2] <= wdata[DW-1:DW/2];
    end
    // two words per entry, low word at the even address
    entry_q_r <= {mem_r[{entry, 1'b1}], mem_r[{entry, 1'b0}]}; // R17
  end

  assign rdata = mem_r[raddr];
endmodule
`default_nettype wire

// *** verilog/ixp_irq_expander.v ***
// interrupt expander: pending flags, enables, group ack, vector fetch, axi4-lite
// Operation
// R1 - peripheral request y of group x sets its pending flag
// R2 - group request goes out only if source enabled and group ack clear
// R3 - forwarding a group request sets that group's ack latch
// R4 - ack latch stays set until software clears it
// R5 - vector fetch returns highest-priority enabled pending source vector
// R6 - none enabled and pending: return group's first source vector
// R7 - delivering a source's vector clears its pending flag
// R8 - 256 x 16 vector memory, also usable as plain data memory
// R9 - vector memory is not cleared by reset
// R10 - lowest-numbered source wins within a group; core orders groups
// R11 - priority decided at vector fetch, not at request time
// R12 - trap or forced interrupt to groups 1..12 gets first source vector
// R13 - other traps and forced interrupts get their own table entry
// R14 - vector memory writes only while protect unlock is set
// R15 - trap to vector zero while enabled returns all-zero address
// R16 - reset vector is never served from this block
// R17 - each entry is two 16-bit words, entry zero at table base
// R18 - forwarded request reaches core flag within 5 cycles
// R19 - software disables a source by the mask, wait, clear sequence
// R20 - software discards a flag via a return-only handler vector
// R21 - peripheral requests only when enabled inside the peripheral
// R22 - core services group when enabled and unmasked, then fetches vector
// R23 - control bit 0 enables vector fetch, resets to zero
// R24 - twelve groups, each with enables, flags and one core line
// R25 - writing one to an ack bit clears it; zero leaves it
`timescale 1ns/100ps
`default_nettype none
`include "ixp_defines.vh"
module ixp_irq_expander #(
  parameter GROUPS = `IXP_GROUPS,
  parameter SRCS   = `IXP_SRCS
) (
  input  wire                     aclk,
  input  wire                     aresetn,
  input  wire [`IXP_ADDR_W-1:0]   awaddr,
  input  wire                     awvalid,
  output wire                     awready,
  input  wire [31:0]              wdata,
  input  wire [3:0]               wstrb,
  input  wire                     wvalid,
  output wire                     wready,
  output wire [1:0]               bresp,
  output wire                     bvalid,
  input  wire                     bready,
  input  wire [`IXP_ADDR_W-1:0]   araddr,
  input  wire                     arvalid,
  output wire                     arready,
  output wire [31:0]              rdata,
  output wire [1:0]               rresp,
  output wire                     rvalid,
  input  wire                     rready,
  input  wire [GROUPS*SRCS-1:0]   periph_irq,
  input  wire                     protect_unlock,
  output wire [GROUPS-1:0]        core_irq,
  input  wire                     vec_req,
  input  wire [6:0]               vec_id,
  input  wire                     vec_trap,
  output wire                     vec_ack,
  output wire                     vec_hit,
  output wire [31:0]              vec_addr
);
  localparam NSRC = GROUPS * SRCS;

  // lowest-numbered set bit of a group, bit 3 flags "found"
  function [3:0] first_src;
    input [7:0] v;
    integer i;
    begin
      first_src = 4'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_src = {1'b1, i[2:0]}; // R10
        end
      end
    end
  endfunction

  function [2:0] region;
    input [`IXP_ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'h0) begin
        region = `IXP_RG_BAD;
      end else if (a == `IXP_OFS_CTRL) begin
        region = `IXP_RG_CTRL;
      end else if (a == `IXP_OFS_ACK) begin
        region = `IXP_RG_ACK;
      end else if ((a[11:6] == `IXP_OFS_EN_BASE >> 6) && (a[5:2] < GROUPS)) begin
        region = `IXP_RG_EN;
      end else if ((a[11:6] == `IXP_OFS_FLG_BASE >> 6) && (a[5:2] < GROUPS)) begin
        region = `IXP_RG_FLG;
      end else if (a[11:10] == `IXP_OFS_RAM_BASE >> 10) begin
        region = `IXP_RG_RAM;
      end else begin
        region = `IXP_RG_BAD;
      end
    end
  endfunction

  reg                   ctrl_r;
  reg [GROUPS-1:0]      ack_r;
  reg [NSRC-1:0]        en_r;
  reg [NSRC-1:0]        flg_r;
  reg [NSRC-1:0]        irq_prev_r;
  reg [GROUPS-1:0]      core_irq_r;

  reg                   awready_r;
  reg                   wready_r;
  reg                   aw_have_r;
  reg                   w_have_r;
  reg [`IXP_ADDR_W-1:0] awaddr_r;
  reg [31:0]            wdata_r;
  reg [3:0]             wstrb_r;
  reg                   bvalid_r;
  reg [1:0]             bresp_r;
  reg                   arready_r;
  reg                   rvalid_r;
  reg [31:0]            rdata_r;
  reg [1:0]             rresp_r;

  reg                   vbusy_r;
  reg                   vzero_r;
  reg                   vtab_r;
  reg                   vec_ack_r;
  reg                   vec_hit_r;
  reg [31:0]            vec_addr_r;

  // bus handshakes
  wire acc_aw = awvalid & awready_r;
  wire acc_w  = wvalid & wready_r;
  wire acc_ar = arvalid & arready_r;
  wire do_wr  = aw_have_r & w_have_r & ~bvalid_r;
  wire aw_nxt = (aw_have_r | acc_aw) & ~do_wr;
  wire w_nxt  = (w_have_r | acc_w) & ~do_wr;
  wire b_nxt  = do_wr | (bvalid_r & ~bready);
  wire r_nxt  = acc_ar | (rvalid_r & ~rready);

  wire [2:0] wr_rg = region(awaddr_r);
  wire [2:0] rd_rg = region(araddr);
  wire [3:0] wr_g  = awaddr_r[5:2];
  wire [3:0] rd_g  = araddr[5:2];

  // vector memory access from the bus
  wire [1:0]  ram_we;
  wire [15:0] ram_rdata;
  wire [31:0] entry_q;
  reg  [6:0]  ent_sel;

  assign ram_we = (do_wr && wr_rg == `IXP_RG_RAM && protect_unlock) ?
                  wstrb_r[1:0] : 2'h0; // R14

  // vector fetch decode, done at fetch time from current enables and flags
  reg  [3:0]      grp_idx;
  reg  [7:0]      grp_pend;
  reg  [3:0]      pick;
  reg  [2:0]      src_sel;
  reg             is_grp;
  reg             v_zero;
  reg             v_tab;
  reg  [NSRC-1:0] vclr;
  wire            v_take = vec_req & ~vbusy_r;

  always @* begin
    grp_idx  = vec_id[3:0] - 4'h1;
    is_grp   = (vec_id >= 7'h01) && (vec_id <= GROUPS);
    grp_pend = en_r[grp_idx*SRCS +: 8] & flg_r[grp_idx*SRCS +: 8]; // R11
    pick     = first_src(grp_pend);
    src_sel  = 3'h0;
    ent_sel  = vec_id; // R13
    v_zero   = 1'b0;
    v_tab    = 1'b0;
    vclr     = {NSRC{1'b0}};
    if (ctrl_r) begin // R23
      if (vec_id == `IXP_RESET_ENTRY) begin
        v_zero = 1'b1; // R15 R16
      end else begin
        v_tab = 1'b1;
        if (is_grp) begin
          if (!vec_trap && pick[3]) begin
            src_sel = pick[2:0]; // R5
            if (v_take) begin
              vclr[grp_idx*SRCS + src_sel] = 1'b1; // R7
            end
          end
          // trap, forced interrupt or nothing pending: first source
          ent_sel = `IXP_GRP_ENTRY_BASE + {grp_idx[3:0], src_sel}; // R6 R12
        end
      end
    end
  end

  ixp_vec_ram #(
    .AW (8),
    .DW (16),
    .EW (7)
  ) u_ram (
    .clk       (aclk),
    .we        (ram_we),
    .waddr     (awaddr_r[9:2]),
    .wdata     (wdata_r[15:0]),
    .entry     (ent_sel),
    .entry_q_r (entry_q),
    .raddr     (araddr[9:2]),
    .rdata     (ram_rdata)
  );

  // group forwarding and ack latch
  reg [GROUPS-1:0] fire;
  reg [GROUPS-1:0] ack_clr;
  integer g;
  always @* begin
    fire    = {GROUPS{1'b0}};
    ack_clr = {GROUPS{1'b0}};
    for (g = 0; g < GROUPS; g = g + 1) begin
      fire[g] = (|(en_r[g*SRCS +: 8] & flg_r[g*SRCS +: 8])) & ~ack_r[g]; // R2 R24
    end
    if (do_wr && wr_rg == `IXP_RG_ACK && wstrb_r[0]) begin
      ack_clr[7:0] = wdata_r[7:0]; // R25
    end
    if (do_wr && wr_rg == `IXP_RG_ACK && wstrb_r[1]) begin
      ack_clr[GROUPS-1:8] = wdata_r[GROUPS-1:8]; // R25
    end
  end

  wire [NSRC-1:0] irq_rise = periph_irq & ~irq_prev_r;

  // read data mux
  reg [31:0] rd_mux;
  reg [1:0]  rd_resp;
  always @* begin
    rd_mux  = 32'h0;
    rd_resp = `IXP_RESP_OKAY;
    case (rd_rg)
      `IXP_RG_CTRL: rd_mux[`IXP_CTRL_FETCH_BIT] = ctrl_r;
      `IXP_RG_ACK:  rd_mux[GROUPS-1:0] = ack_r;
      `IXP_RG_EN:   rd_mux[7:0] = en_r[rd_g*SRCS +: 8];
      `IXP_RG_FLG:  rd_mux[7:0] = flg_r[rd_g*SRCS +: 8];
      `IXP_RG_RAM:  rd_mux[15:0] = ram_rdata; // R8
      default:      rd_resp = `IXP_RESP_SLVERR;
    endcase
  end

  // control and interrupt state
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= `IXP_CTRL_RST; // R23
      ack_r      <= `IXP_ACK_RST;
      en_r       <= `IXP_EN_RST;
      flg_r      <= `IXP_FLG_RST;
      irq_prev_r <= {NSRC{1'b0}};
      core_irq_r <= {GROUPS{1'b0}};
    end else begin
      irq_prev_r <= periph_irq;
      // new request wins over a same-cycle fetch clear
      flg_r      <= (flg_r & ~vclr) | irq_rise; // R1 R21
      // forwarding sets the latch even against a software clear
      ack_r      <= (ack_r & ~ack_clr) | fire; // R3 R4
      core_irq_r <= fire; // R18
      if (do_wr && wr_rg == `IXP_RG_CTRL && wstrb_r[0]) begin
        ctrl_r <= wdata_r[`IXP_CTRL_FETCH_BIT];
      end
      if (do_wr && wr_rg == `IXP_RG_EN && wstrb_r[0]) begin
        en_r[wr_g*SRCS +: 8] <= wdata_r[7:0];
      end
    end
  end

  // vector fetch answer: on the edge after the request is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      vbusy_r    <= 1'b0;
      vzero_r    <= 1'b0;
      vtab_r     <= 1'b0;
      vec_ack_r  <= 1'b0;
      vec_hit_r  <= 1'b0;
      vec_addr_r <= `IXP_ZERO_VECTOR;
    end else begin
      vec_ack_r <= vbusy_r;
      if (v_take) begin
        vbusy_r <= 1'b1;
        vzero_r <= v_zero;
        vtab_r  <= v_tab;
      end else begin
        vbusy_r <= 1'b0;
      end
      if (vbusy_r) begin
        vec_hit_r  <= vtab_r | vzero_r;
        vec_addr_r <= vtab_r ? entry_q : `IXP_ZERO_VECTOR; // R15 R17
      end
    end
  end

  // axi4-lite slave
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= {`IXP_ADDR_W{1'b0}};
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `IXP_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= `IXP_RESP_OKAY;
    end else begin
      aw_have_r <= aw_nxt;
      w_have_r  <= w_nxt;
      awready_r <= ~aw_nxt & ~b_nxt;
      wready_r  <= ~w_nxt & ~b_nxt;
      bvalid_r  <= b_nxt;
      arready_r <= ~r_nxt;
      rvalid_r  <= r_nxt;
      if (acc_aw) begin
        awaddr_r <= awaddr;
      end
      if (acc_w) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_wr) begin
        // flags are read-only; a locked vector write is dropped quietly
        bresp_r <= (wr_rg == `IXP_RG_BAD) ? `IXP_RESP_SLVERR : `IXP_RESP_OKAY;
      end
      if (acc_ar) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_resp;
      end
    end
  end

  assign awready  = awready_r;
  assign wready   = wready_r;
  assign bresp    = bresp_r;
  assign bvalid   = bvalid_r;
  assign arready  = arready_r;
  assign rdata    = rdata_r;
  assign rresp    = rresp_r;
  assign rvalid   = rvalid_r;
  assign core_irq = core_irq_r;
  assign vec_ack  = vec_ack_r;
  assign vec_hit  = vec_hit_r;
  assign vec_addr = vec_addr_r;
endmodule
`default_nettype wire

// *** verif/ixp_irq_expander_checker.sv ***
// checker on the core-side ports of the interrupt expander
`timescale 1ns/100ps
`default_nettype none
module ixp_irq_expander_checker #(
  parameter GROUPS = 12
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [GROUPS-1:0] core_irq,
  input wire logic              vec_req,
  input wire logic [6:0]        vec_id,
  input wire logic              vec_ack,
  input wire logic              vec_hit,
  input wire logic [31:0]       vec_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [GROUPS-1:0] armed_r;
  logic              wr_seen_r;
  // a group may fire again only after a bus write
  always @(posedge aclk) begin
    if (!aresetn) begin
      armed_r   <= '1;
      wr_seen_r <= 1'b0;
    end else if (awvalid && awready) begin
      armed_r   <= '1;
      wr_seen_r <= 1'b1;
    end else begin
      armed_r <= armed_r & ~core_irq;
    end
  end
  vec_late_a: assert property (vec_req |-> ##2 vec_ack)
    else $error("vector answer late");
  vec_cause_a: assert property (vec_ack |-> $past(vec_req, 2))
    else $error("vector answer without request");
  zero_vec_a: assert property (vec_req && vec_id == 7'h00 |-> ##2 vec_addr == 32'h0)
    else $error("trap zero gave nonzero address");
  off_addr_a: assert property (vec_ack && !vec_hit |-> vec_addr == 32'h0)
    else $error("disabled fetch gave address");
  off_reset_a: assert property (vec_ack && !wr_seen_r |-> !vec_hit)
    else $error("fetch enabled out of reset");
  addr_hold_a: assert property (!vec_ack && $past(aresetn) |-> $stable(vec_addr))
    else $error("vector address moved between answers");
  one_pulse_a: assert property (|core_irq |=> (core_irq & $past(core_irq)) == '0)
    else $error("group request longer than one cycle");
  rearm_wr_a: assert property ((core_irq & ~armed_r) == '0)
    else $error("group refired without ack clear");
endmodule
bind ixp_irq_expander ixp_irq_expander_checker #(.GROUPS(GROUPS)) u_chk (
  .aclk, .aresetn, .awvalid, .awready, .core_irq,
  .vec_req, .vec_id, .vec_ack, .vec_hit, .vec_addr
);
`default_nettype wire

// *** verif/ixp_core_model.sv ***
// core-side model: services forwarded group requests and issues traps
`timescale 1ns/100ps
`default_nettype none
module ixp_core_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] core_irq,
  input  wire logic        cmd_go,
  input  wire logic [6:0]  cmd_id,
  input  wire logic        cmd_trap,
  input  wire logic [3:0]  dly,
  output var  logic        vec_req,
  output var  logic [6:0]  vec_id,
  output var  logic        vec_trap
);
  logic       busy_r;
  logic [3:0] cnt_r;
  logic [6:0] grp_r;
  always @(posedge aclk) begin
    vec_req  <= 1'b0;
    vec_id   <= ~vec_id;  // no stale id between requests
    vec_trap <= ~vec_trap;
    if (!aresetn) begin
      busy_r   <= 1'b0;
      vec_id   <= 7'h00;
      vec_trap <= 1'b0;
    end else if (cmd_go) begin
      vec_req  <= 1'b1;
      vec_id   <= cmd_id;
      vec_trap <= cmd_trap;
    end else if (|core_irq) begin
      busy_r <= 1'b1;
      cnt_r  <= dly;
      for (int g = 11; g >= 0; g--)
        if (core_irq[g]) grp_r <= 7'(g + 1);
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h0) begin
        busy_r   <= 1'b0;
        vec_req  <= 1'b1;
        vec_id   <= grp_r;
        vec_trap <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// testbench of the interrupt expander
`timescale 1ns/100ps
`default_nettype none
`include "ixp_defines.vh"
module tb;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic        bready = 1, rready = 1, protect_unlock = 0, cmd_go = 0, cmd_trap = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 4'hf, dly = 4'h6;
  logic [95:0] periph_irq = '0;
  logic [6:0]  cmd_id = 0, vec_id;
  logic        awready, wready, bvalid, arready, rvalid, vec_req, vec_trap, vec_ack, vec_hit;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, vec_addr;
  logic [11:0] core_irq;
  logic [33:0] rq[$], bq[$], vq[$];
  logic [31:0] vt[0:47];
  int          seed = 57, mismatches = 0, checks_done = 0;
  always #2.5 aclk = ~aclk;
  ixp_irq_expander u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .periph_irq, .protect_unlock, .core_irq, .vec_req, .vec_id, .vec_trap,
    .vec_ack, .vec_hit, .vec_addr);
  ixp_core_model u_core (.aclk, .aresetn, .core_irq, .cmd_go, .cmd_id, .cmd_trap, .dly,
    .vec_req, .vec_id, .vec_trap);
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  always @(posedge aclk) begin
    if (rvalid === 1'b1) chk("rdata", rq.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1) chk("bresp", bq.pop_front(), {32'h0, bresp});
    if (vec_ack === 1'b1) chk("vector", vq.pop_front(), {1'b0, vec_hit, vec_addr});
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back({32'h0, r});
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    fork
      begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (!bvalid);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask
  task automatic drain;
    while (vq.size() != 0) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask
  task automatic vx(input logic [6:0] i, input logic t, input logic [32:0] e);
    vq.push_back({1'b0, e});
    @(posedge aclk);
    cmd_go <= 1'b1; cmd_id <= i; cmd_trap <= t;
    @(posedge aclk);
    cmd_go <= 1'b0;
    drain;
  endtask
  task final_report;
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`IXP_OFS_CTRL, 34'h0);
    rd(12'h100, {`IXP_RESP_SLVERR, 32'h0});
    vx(7'h05, 1'b1, 33'h0);
    protect_unlock <= 1'b1;
    for (int e = 16; e < 48; e++) begin
      vt[e] = $random(seed);
      wr(`IXP_OFS_RAM_BASE + 12'(8 * e), vt[e], `IXP_RESP_OKAY);
      wr(`IXP_OFS_RAM_BASE + 12'(8 * e + 4), {vt[e][15:0], vt[e][31:16]}, 2'h0);
    end
    wr(`IXP_OFS_CTRL, 32'h1, `IXP_RESP_OKAY);
    protect_unlock <= 1'b0;
    wr(`IXP_OFS_RAM_BASE + 12'h0a0, ~vt[20], `IXP_RESP_OKAY);
    rd(`IXP_OFS_RAM_BASE + 12'h0a0, {18'h0, vt[20][15:0]});
    vx(7'h00, 1'b1, {1'b1, 32'h0});
    vx(7'h14, 1'b1, {1'b1, vt[20]});
    for (int g = 1; g <= 2; g++) vx(7'(g), 1'b1, {1'b1, vt[24 + 8 * g]});
    wr(`IXP_OFS_EN_BASE, 32'h24, `IXP_RESP_OKAY);
    vq.push_back({2'b01, vt[34]});
    periph_irq[0] <= 1'b1;
    periph_irq[5] <= 1'b1;
    do @(posedge aclk); while (!core_irq[0]);
    periph_irq[2] <= 1'b1;
    drain;
    vx(7'h01, 1'b1, {1'b1, vt[32]});
    rd(`IXP_OFS_FLG_BASE, {2'h0, 32'h21});
    rd(`IXP_OFS_ACK, {2'h0, 32'h1});
    vq.push_back({2'b01, vt[37]});
    wr(`IXP_OFS_ACK, 32'h1, `IXP_RESP_OKAY);
    drain;
    rd(`IXP_OFS_FLG_BASE, {2'h0, 32'h1});
    wr(`IXP_OFS_ACK, 32'h0, `IXP_RESP_OKAY);
    rd(`IXP_OFS_ACK, {2'h0, 32'h1});
    wr(`IXP_OFS_ACK, 32'h1, `IXP_RESP_OKAY);
    rd(`IXP_OFS_ACK, {2'h0, 32'h0});
    vx(7'h01, 1'b0, {1'b1, vt[32]});
    rd(`IXP_OFS_FLG_BASE, {2'h0, 32'h1});
    dly <= 4'h0;
    wr(`IXP_OFS_EN_BASE + 12'h004, 32'h1, `IXP_RESP_OKAY);
    vq.push_back({2'b01, vt[40]});
    periph_irq[8] <= 1'b1;
    drain;
    wr(`IXP_OFS_EN_BASE + 12'h004, 32'h3, `IXP_RESP_OKAY);
    periph_irq[9] <= 1'b1;
    wr(`IXP_OFS_FLG_BASE + 12'h004, 32'h0, `IXP_RESP_OKAY);
    wr(`IXP_OFS_EN_BASE + 12'h004, 32'h0, `IXP_RESP_OKAY);
    repeat (5) @(posedge aclk);
    wr(`IXP_OFS_ACK, 32'h2, `IXP_RESP_OKAY);
    rd(`IXP_OFS_FLG_BASE + 12'h004, {2'h0, 32'h2});
    rd(`IXP_OFS_ACK, {2'h0, 32'h0});
    protect_unlock <= 1'b1;
    wr(`IXP_OFS_RAM_BASE + 12'h148, 32'h1234, `IXP_RESP_OKAY);
    wr(`IXP_OFS_RAM_BASE + 12'h14c, 32'h0, `IXP_RESP_OKAY);
    vq.push_back({2'b01, 32'h0000_1234});
    wr(`IXP_OFS_EN_BASE + 12'h004, 32'h2, `IXP_RESP_OKAY);
    drain;
    wr(`IXP_OFS_RAM_BASE + 12'h148, vt[41], `IXP_RESP_OKAY);
    wr(`IXP_OFS_RAM_BASE + 12'h14c, {16'h0, vt[41][31:16]}, `IXP_RESP_OKAY);
    protect_unlock <= 1'b0;
    wr(`IXP_OFS_EN_BASE + 12'h004, 32'h0, `IXP_RESP_OKAY);
    wr(`IXP_OFS_ACK, 32'h2, `IXP_RESP_OKAY);
    rd(`IXP_OFS_FLG_BASE + 12'h004, {2'h0, 32'h0});
    wr(12'h002, 32'h0, `IXP_RESP_SLVERR);
    rd(`IXP_OFS_CTRL, {2'h0, 32'h1});
    vx(7'h29, 1'b1, {1'b1, vt[41]});
    final_report;
  end
endmodule
`default_nettype wire
